// >>> rtl/pci_pkg.sv
/*
 * Package for the pin-change interrupt unit: register map, field
 * positions, reset values and the carrier structs.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package pci_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PCI_NPINS = 6;
  localparam int PCI_REG_W = 8;
  localparam int PCI_ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [PCI_ADDR_W-1:0] PCI_OFF_RISE = 8'h00;
  localparam logic [PCI_ADDR_W-1:0] PCI_OFF_FALL = 8'h04;
  localparam logic [PCI_ADDR_W-1:0] PCI_OFF_FLAGS = 8'h08;
  localparam logic [PCI_ADDR_W-1:0] PCI_OFF_INTCTL = 8'h0c;
  localparam logic [PCI_ADDR_W-1:0] PCI_OFF_IRQ_STAT = 8'h10;
  localparam logic [PCI_ADDR_W-1:0] PCI_OFF_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // int_control_reg: change_int_enable and change_int_summary
  localparam int PCI_INTCTL_IE_BIT = 3;
  localparam int PCI_INTCTL_SUM_BIT = 0;
  // Interrupt status and mask: a single event bit, bit 0, for all flags
  localparam int PCI_IRQ_EVT_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PCI_NPINS-1:0] PCI_RST_EN = 6'h00;
  localparam logic [PCI_NPINS-1:0] PCI_RST_FLAGS = 6'h00;
  localparam logic PCI_RST_IE = 1'b0;
  localparam logic PCI_RST_MASK = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PCI_NPINS-1:0] rise;
    logic [PCI_NPINS-1:0] fall;
  } pci_edges_s;

  typedef struct packed {
    logic [PCI_NPINS-1:0] rise_enable;
    logic [PCI_NPINS-1:0] fall_enable;
  } pci_cfg_s;

endpackage

// >>> rtl/pci_edge_detect.sv
/*
 * Per-pin synchroniser and edge detector for the pin-change unit.
 * Assumes asynchronous pin inputs and a single system clock.
 */
`timescale 1ns/1ps
module pci_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pci_pkg::PCI_NPINS-1:0] pins,
  output pci_pkg::pci_edges_s edges
);
  import pci_pkg::*;

  // ----------------------------------------------------------------
  // Two-flop synchroniser, then one history stage
  // ----------------------------------------------------------------
  logic [PCI_NPINS-1:0] meta_reg, meta_next;
  logic [PCI_NPINS-1:0] sync_reg, sync_next;
  logic [PCI_NPINS-1:0] prev_reg, prev_next;

  always_comb begin
    meta_next = pins;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 6'h00;
      sync_reg <= 6'h00;
      prev_reg <= 6'h00;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // One pulse per edge: compare only settled samples
  assign edges = '{rise: sync_reg & ~prev_reg,
                   fall: ~sync_reg & prev_reg};

  a_edge_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edges.rise | edges.fall) != 6'h00 |=>
    (edges.rise & $past(edges.rise)) == 6'h00 &&
    (edges.fall & $past(edges.fall)) == 6'h00)
    else $error("edge pulse lasted more than one cycle");

endmodule // pci_edge_detect

// >>> rtl/pci_top.sv
/*
 * Pin-change interrupt unit for a six-pin port, with APB registers.
 * Assumes pins are asynchronous and the APB master meets the protocol.
 */
// Summary of operation
// - rise_enable bit arms rising-edge detection on its pin.
// - fall_enable bit arms falling-edge detection on its pin.
// - Enabled edge of matching direction sets the pin's change flag.
// - A change flag stays set until software writes it to zero.
// - With change_int_enable set, a detection raises the wake request.
// - Edges during sleep are flagged before the core resumes.
// - Bits 7 and 6 of the three pin registers ignore writes, read zero.
// - Detection and flagging continue while change_int_enable is clear.
// - change_int_summary is the read-only OR of all change flags.
// - An edge in the cycle of a flag write leaves the flag set.
// - Both enables set flag transitions in either direction.
`timescale 1ns/1ps
module pci_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pci_pkg::PCI_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pci_pkg::PCI_NPINS-1:0] port_a_pin,
  output logic change_int_req,
  output logic wake_req,
  output logic irq
);
  import pci_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pci_zext(input logic [PCI_NPINS-1:0] v);
    pci_zext = {26'h0, v};
  endfunction

  function automatic logic pci_is_mapped(input logic [PCI_ADDR_W-1:0] a);
    pci_is_mapped = (a == PCI_OFF_RISE) || (a == PCI_OFF_FALL) ||
                    (a == PCI_OFF_FLAGS) || (a == PCI_OFF_INTCTL) ||
                    (a == PCI_OFF_IRQ_STAT) || (a == PCI_OFF_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  pci_edges_s edges;

  pci_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pins(port_a_pin),
    .edges(edges)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  pci_cfg_s cfg_reg, cfg_next;
  logic [PCI_NPINS-1:0] flags_reg, flags_next;
  logic ie_reg, ie_next;
  logic irq_stat_reg, irq_stat_next;
  logic irq_mask_reg, irq_mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic change_int_reg, change_int_next;
  logic wake_reg, wake_next;
  logic irq_reg, irq_next;

  logic [PCI_NPINS-1:0] detect;
  logic setup_ph;
  logic wr_en;
  logic any_detect;
  logic [PCI_NPINS-1:0] rise_hit;
  logic [PCI_NPINS-1:0] fall_hit;
  logic [PCI_NPINS-1:0] dual_hit;
  logic [PCI_NPINS-1:0] fresh_hit;

  // Access completes one cycle after setup; pready high in that cycle
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pready_reg && pwrite;

  // Rising and falling arms are independent; both give either way
  assign detect = (edges.rise & cfg_reg.rise_enable) |
                  (edges.fall & cfg_reg.fall_enable);
  assign any_detect = |detect;

  // Named terms so the checks can look one cycle back
  assign rise_hit = edges.rise & cfg_reg.rise_enable;
  assign fall_hit = edges.fall & cfg_reg.fall_enable;
  assign dual_hit = (edges.rise | edges.fall) & cfg_reg.rise_enable &
                    cfg_reg.fall_enable;
  assign fresh_hit = detect & ~flags_reg;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    flags_next = flags_reg;
    ie_next = ie_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = setup_ph;

    // Only bits 5..0 exist, upper write data dropped
    if (wr_en && pci_is_mapped(paddr)) begin
      unique case (paddr)
        PCI_OFF_RISE: begin
          cfg_next.rise_enable = pwdata[PCI_NPINS-1:0];
        end
        PCI_OFF_FALL: begin
          cfg_next.fall_enable = pwdata[PCI_NPINS-1:0];
        end
        PCI_OFF_FLAGS: begin
          // Writing zero clears; writing one is kept as written
          flags_next = pwdata[PCI_NPINS-1:0];
        end
        PCI_OFF_INTCTL: begin
          ie_next = pwdata[PCI_INTCTL_IE_BIT];
        end
        PCI_OFF_IRQ_STAT: begin
          if (pwdata[PCI_IRQ_EVT_BIT]) begin
            irq_stat_next = 1'b0;
          end
        end
        PCI_OFF_IRQ_MASK: begin
          irq_mask_next = pwdata[PCI_IRQ_EVT_BIT];
        end
        default: begin
        end
      endcase
    end

    // Hardware set beats the software write
    // Flagging does not depend on the master enable
    flags_next = flags_next | detect;
    if (any_detect) begin
      irq_stat_next = 1'b1;
    end

    if (setup_ph) begin
      pslverr_next = !pci_is_mapped(paddr);
      unique case (paddr)
        PCI_OFF_RISE: prdata_next = pci_zext(cfg_reg.rise_enable);
        PCI_OFF_FALL: prdata_next = pci_zext(cfg_reg.fall_enable);
        PCI_OFF_FLAGS: prdata_next = pci_zext(flags_reg);
        PCI_OFF_INTCTL: begin
          prdata_next = 32'h00000000;
          prdata_next[PCI_INTCTL_IE_BIT] = ie_reg;
          prdata_next[PCI_INTCTL_SUM_BIT] = |flags_reg;
        end
        PCI_OFF_IRQ_STAT: prdata_next = {31'h0, irq_stat_reg};
        PCI_OFF_IRQ_MASK: prdata_next = {31'h0, irq_mask_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end

    // Summary read-only; request only with master enable
    change_int_next = ie_next && (|flags_next);
    // Flag and wake land together, so flag is visible on wake
    wake_next = ie_next && (|flags_next);
    irq_next = irq_stat_next && irq_mask_next;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= {PCI_RST_EN, PCI_RST_EN};
      flags_reg <= PCI_RST_FLAGS;
      ie_reg <= PCI_RST_IE;
      irq_stat_reg <= 1'b0;
      irq_mask_reg <= PCI_RST_MASK;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      change_int_reg <= 1'b0;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      flags_reg <= flags_next;
      ie_reg <= ie_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      change_int_reg <= change_int_next;
      wake_reg <= wake_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign change_int_req = change_int_reg;
  assign wake_req = wake_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rise_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_hit != 6'h00 |=> (flags_reg & $past(rise_hit)) == $past(rise_hit))
    else $error("enabled rising edge did not set flag");

  a_rise_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == PCI_OFF_RISE |=>
    cfg_reg.rise_enable == $past(pwdata[PCI_NPINS-1:0]))
    else $error("rise enable write did not land");

  a_fall_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall_hit != 6'h00 |=> (flags_reg & $past(fall_hit)) == $past(fall_hit))
    else $error("enabled falling edge did not set flag");

  a_fall_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == PCI_OFF_FALL |=>
    cfg_reg.fall_enable == $past(pwdata[PCI_NPINS-1:0]))
    else $error("fall enable write did not land");

  a_flag_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_en |=> (flags_reg & ~$past(flags_reg)) == $past(fresh_hit))
    else $error("flag set without enabled edge");

  a_stat_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    any_detect |=> irq_stat_reg)
    else $error("detection did not set interrupt status");

  a_flag_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == PCI_OFF_FLAGS) |=>
    ($past(flags_reg) & ~flags_reg) == 6'h00)
    else $error("flag cleared without software write");

  a_flag_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == PCI_OFF_FLAGS |=>
    flags_reg == ($past(pwdata[PCI_NPINS-1:0]) | $past(detect)))
    else $error("flag write gave wrong value");

  a_wake_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    ie_reg && any_detect && !(wr_en && paddr == PCI_OFF_INTCTL) |=>
    wake_req && change_int_req)
    else $error("wake request missing after detection");

  a_req_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    change_int_req == (ie_reg && flags_reg != 6'h00) &&
    wake_req == change_int_req)
    else $error("request level not enable and any flag");

  a_ie_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == PCI_OFF_INTCTL |=>
    ie_reg == $past(pwdata[PCI_INTCTL_IE_BIT]))
    else $error("master enable write did not land");

  a_wake_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(wake_req) |-> flags_reg != 6'h00)
    else $error("wake raised before flag recorded");

  a_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && (paddr == PCI_OFF_RISE || paddr == PCI_OFF_FALL ||
    paddr == PCI_OFF_FLAGS) |-> prdata[31:PCI_NPINS] == '0)
    else $error("unimplemented bits read nonzero");

  a_err_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && pslverr |-> prdata == 32'h00000000)
    else $error("unmapped read returned nonzero");

  a_flag_no_ie: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ie_reg && any_detect && !(wr_en && paddr == PCI_OFF_INTCTL) |=>
    flags_reg != 6'h00 && !wake_req)
    else $error("flagging blocked or wake raised without enable");

  a_quiet_no_ie: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ie_reg && !(wr_en && paddr == PCI_OFF_INTCTL) |=> !change_int_req)
    else $error("request raised with master enable clear");

  a_summary_or: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == PCI_OFF_INTCTL |->
    prdata[PCI_INTCTL_SUM_BIT] == |$past(flags_reg))
    else $error("summary bit not OR of flags");

  a_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == PCI_OFF_FLAGS && any_detect |=>
    (flags_reg & $past(detect)) == $past(detect))
    else $error("edge lost during flag write");

  a_both_edges: assert property (
    @(posedge pclk) disable iff (!presetn)
    dual_hit != 6'h00 |=> (flags_reg & $past(dual_hit)) == $past(dual_hit))
    else $error("dual-enabled pin missed an edge");

endmodule // pci_top

// >>> test/pci_pin_model.sv
/*
 * Partner model: the external port pins and the sleeping CPU core.
 * Assumes the bench calls drive() just after a rising pclk edge.
 */
`timescale 1ns/1ps
module pci_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wake_req,
  output logic [pci_pkg::PCI_NPINS-1:0] port_a_pin,
  output logic cpu_asleep
);
  import pci_pkg::*;
  // ----------------------------------------------------------------
  // Pins and core state
  // ----------------------------------------------------------------
  initial begin
    port_a_pin = '0;
    cpu_asleep = 1'b0;
  end
  // Caller holds each level for several clocks, so no edge is lost
  task automatic drive(input logic [PCI_NPINS-1:0] v);
    port_a_pin <= v;
  endtask
  task automatic go_to_sleep();
    cpu_asleep <= 1'b1;
  endtask
  // Core resumes on the wake request or on reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_asleep <= 1'b0;
    end else if (cpu_asleep && wake_req) begin
      cpu_asleep <= 1'b0;
    end
  end
endmodule // pci_pin_model

// >>> test/pci_top_tb_top.sv
/*
 * Self-checking bench for the pin-change unit: APB tasks and tests.
 * Assumes an APB slave; the bus task waits for pready however long.
 */
`timescale 1ns/1ps
module pci_top_tb_top;
  import pci_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic change_int_req, wake_req, irq, cpu_asleep, slv_err;
  logic [PCI_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [PCI_NPINS-1:0] port_a_pin;
  int errors, comparisons, lat;
  pci_top pci_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_pin(port_a_pin), .change_int_req(change_int_req),
    .wake_req(wake_req), .irq(irq));
  pci_pin_model pci_pin_model_inst (.pclk(pclk), .presetn(presetn),
    .wake_req(wake_req), .port_a_pin(port_a_pin), .cpu_asleep(cpu_asleep));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits an edge first so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [PCI_ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [PCI_ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [PCI_ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100us;
    errors++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0);
    rchk(8'h18, 32'h0);
    check(32'(slv_err), 32'h1);
    // Upper bits of the three pin registers stay zero
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 * i), 32'hff);
      rchk(8'(4 * i), 32'h3f);
      wr(8'(4 * i), 32'h0);
      rchk(8'(4 * i), 32'h0);
    end
    // Mixed enables, master enable off
    wr(PCI_OFF_RISE, 32'h15);
    wr(PCI_OFF_FALL, 32'h2a);
    pci_pin_model_inst.drive(6'h3f);
    repeat (8) @(posedge pclk);
    rchk(PCI_OFF_FLAGS, 32'h15);
    check(32'(change_int_req), 32'h0);
    wr(PCI_OFF_INTCTL, 32'h0);
    rchk(PCI_OFF_INTCTL, 32'h1);
    pci_pin_model_inst.drive(6'h00);
    repeat (30) @(posedge pclk);
    rchk(PCI_OFF_FLAGS, 32'h3f);
    // Clear only what was observed earlier
    apb(1'b0, PCI_OFF_FLAGS, 32'h0);
    wr(PCI_OFF_FLAGS, rd & ~32'h15);
    rchk(PCI_OFF_FLAGS, 32'h2a);
    wr(PCI_OFF_FLAGS, 32'h0);
    rchk(PCI_OFF_INTCTL, 32'h0);
    // Interrupt status, mask and clear
    rchk(PCI_OFF_IRQ_STAT, 32'h1);
    check(32'(irq), 32'h0);
    wr(PCI_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h1);
    wr(PCI_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    rchk(PCI_OFF_IRQ_STAT, 32'h0);
    // Wake from sleep, both edges on one pin
    wr(PCI_OFF_RISE, 32'h20);
    wr(PCI_OFF_FALL, 32'h20);
    wr(PCI_OFF_INTCTL, 32'h8);
    @(posedge pclk);
    pci_pin_model_inst.go_to_sleep();
    pci_pin_model_inst.drive(6'h20);
    for (lat = 1; lat < 20; lat++) begin
      @(posedge pclk);
      #1;
      if (change_int_req === 1'b1) break;
    end
    check(32'(lat), 32'h3);
    check(32'(wake_req), 32'h1);
    @(posedge pclk);
    #1;
    check(32'(cpu_asleep), 32'h0);
    rchk(PCI_OFF_FLAGS, 32'h20);
    wr(PCI_OFF_FLAGS, 32'h0);
    pci_pin_model_inst.drive(6'h00);
    repeat (8) @(posedge pclk);
    rchk(PCI_OFF_FLAGS, 32'h20);
    wr(PCI_OFF_FLAGS, 32'h0);
    repeat (2) @(posedge pclk);
    check(32'(change_int_req), 32'h0);
    // Edge lands on the very edge that writes the flag to zero
    pci_pin_model_inst.drive(6'h20);
    wr(PCI_OFF_FLAGS, 32'h0);
    rchk(PCI_OFF_FLAGS, 32'h20);
    // Mid-run reset returns registers and requests to zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(PCI_OFF_FLAGS, 32'h0);
    check(32'(wake_req), 32'h0);
    rchk(PCI_OFF_RISE, 32'h0);
    rchk(PCI_OFF_INTCTL, 32'h0);
    report_and_stop();
  end
endmodule // pci_top_tb_top
